/* rtl/lpcal_pkg.sv */
// Register map, field layout, reset values and delay tables for the
// low-power calibration control and calibration-data port.
// Assumes APB with 32-bit data; the index of a register times four is its
// byte address.
package lpcal_pkg;
    // Register indices; byte address is index times four
    localparam logic [7:0]  IDX_LP_CTRL  = 8'h6E;
    localparam logic [7:0]  IDX_DATA_EN  = 8'h70;
    localparam logic [7:0]  IDX_DATA     = 8'h71;
    localparam logic [7:0]  IDX_CFG      = 8'h72;
    localparam logic [7:0]  IDX_STATUS   = 8'h73;
    localparam int          ADDR_W       = 12;
    localparam int          IDX_LSB      = 2;
    localparam int          IDX_MSB      = 9;
    // Reset values
    localparam logic [7:0]  LP_CTRL_RST  = 8'h88;
    localparam logic [7:0]  DATA_EN_RST  = 8'h00;
    localparam logic [7:0]  CFG_RST      = 8'h04;
    // Low-power control fields and data-enable bit
    localparam int          SLEEP_MSB    = 7;
    localparam int          SLEEP_LSB    = 5;
    localparam int          WAKE_MSB     = 4;
    localparam int          WAKE_LSB     = 3;
    localparam int          TRIG_BIT     = 1;
    localparam int          LPEN_BIT     = 0;
    localparam int          DEN_BIT      = 0;
    // Configuration fields
    localparam int          CFG_BG_BIT   = 0;
    localparam int          CFG_SEL_BIT  = 1;
    localparam int          CFG_SOFT_BIT = 2;
    // Calibration vector
    localparam int          VEC_LEN      = 673;
    localparam int          PTR_W        = 10;
    localparam logic [9:0]  PTR_LAST     = 10'h2A0;
    // Delay in clock periods is (2^k + 1) x unit
    localparam int          CNT_W        = 48;
    localparam logic [47:0] DLY_UNIT     = 48'h100;
    localparam logic [47:0] SLEEP_EXP_DEF =
        {6'h21, 6'h1E, 6'h1B, 6'h18, 6'h15, 6'h12, 6'h0F, 6'h03};
    localparam logic [23:0] WAKE_EXP_DEF = {6'h18, 6'h15, 6'h12, 6'h03};
    localparam int          EXP_W        = 6;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SLEEP,
        ST_SETTLE,
        ST_CAL
    } lpcal_state_t;
endpackage : lpcal_pkg

/* rtl/lpcal_top.sv */
// Low-power background calibration sequencer and calibration-data port.
// Assumes an APB master on clk and an outside calibration engine that
// reports halt, foreground completion and end of each calibration cycle.
//
// How it works
// [RQ1] Autonomous sleep lasts (2^k+1)x256 clocks, code 4
// [RQ2] Wake settling lasts (2^k+1)x256 clocks, code 1
// [RQ3] Sleep field only in autonomous mode, wake always
// [RQ4] Mode 0 timed sleep, mode 1 waits trigger
// [RQ5] Triggered mode wakes while trigger is low
// [RQ6] Low-power enable resets off, needs background enable
// [RQ7] Software avoids sleep codes below 4
// [RQ8] Software avoids wake settling code 0
// [RQ9] Data port works only while enable set
// [RQ10] Each read returns next byte, 673 reads
// [RQ11] Each write loads next byte, 673 writes
// [RQ12] Software may stream with address hold
// [RQ13] Data access only while calibration stopped; an access while running still goes through and sets access_err
// [RQ14] Abandoned sequence leaves calibration data invalid
// [RQ15] Stopped flag follows halt or foreground done
// [RQ16] Trigger from soft bit or pin by select
// [RQ17] Sleep, settle, calibrate loop; counters restart
// [RQ18] Pointer restarts when data enable newly set
`timescale 1ns/1ps
module lpcal_top #(
    parameter logic [47:0] CYC_UNIT   = lpcal_pkg::DLY_UNIT,
    parameter logic [47:0] SLEEP_EXPS = lpcal_pkg::SLEEP_EXP_DEF,
    parameter logic [23:0] WAKE_EXPS  = lpcal_pkg::WAKE_EXP_DEF
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rstn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Calibration trigger pin
    input  wire logic        cal_trigger_input,
    // Calibration engine
    input  wire logic        bg_cal_halted,
    input  wire logic        fg_cal_done,
    input  wire logic        cal_cycle_done,
    output logic             core_sleep,
    output logic             cal_run,
    // Engine read port into the calibration vector
    input  wire logic [9:0]  vec_rd_addr,
    output logic      [7:0]  vec_rd_data
);
    logic [7:0]                       lp_ctrl;
    logic [7:0]                       data_en_reg;
    logic                             background_cal_enable;
    logic                             trigger_source_select;
    logic                             software_cal_trigger;
    logic                             cal_stopped;
    logic                             access_err;
    logic [lpcal_pkg::PTR_W-1:0]      ptr;
    logic [lpcal_pkg::CNT_W-1:0]      cnt;
    logic [7:0]                       vec_mem [lpcal_pkg::VEC_LEN];
    lpcal_pkg::lpcal_state_t          state;
    lpcal_pkg::lpcal_state_t          next_state;

    // Register fields
    wire [2:0] sleep_duration_code =
        lp_ctrl[lpcal_pkg::SLEEP_MSB:lpcal_pkg::SLEEP_LSB];
    wire [1:0] wake_settle_code =
        lp_ctrl[lpcal_pkg::WAKE_MSB:lpcal_pkg::WAKE_LSB];
    wire triggered_sleep_mode = lp_ctrl[lpcal_pkg::TRIG_BIT];
    wire lowpower_cal_enable  = lp_ctrl[lpcal_pkg::LPEN_BIT];
    wire port_en              = data_en_reg[lpcal_pkg::DEN_BIT];

    // APB decode
    wire [7:0] idx     = paddr[lpcal_pkg::IDX_MSB:lpcal_pkg::IDX_LSB];
    wire addr_clean    = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0);
    wire hit_ctrl      = addr_clean && (idx == lpcal_pkg::IDX_LP_CTRL);
    wire hit_den       = addr_clean && (idx == lpcal_pkg::IDX_DATA_EN);
    wire hit_data      = addr_clean && (idx == lpcal_pkg::IDX_DATA);
    wire hit_cfg       = addr_clean && (idx == lpcal_pkg::IDX_CFG);
    wire hit_stat      = addr_clean && (idx == lpcal_pkg::IDX_STATUS);
    wire mapped = hit_ctrl | hit_den | hit_data | hit_cfg | hit_stat;
    wire acc_first     = psel & penable & ~pready;
    wire acc_done      = psel & penable & pready;
    wire wr_done       = acc_done & pwrite & mapped;
    wire data_acc      = acc_done & hit_data & port_en;      // [RQ9]
    wire data_wr       = data_acc & pwrite;                  // [RQ11]
    wire en_newly_set  = wr_done & hit_den & ~port_en &
                         pwdata[lpcal_pkg::DEN_BIT];         // [RQ18]
    wire ptr_at_end    = (ptr == lpcal_pkg::PTR_LAST);
    wire [lpcal_pkg::PTR_W-1:0] ptr_inc = ptr_at_end ?
        '0 : ptr + 10'h001;                                  // [RQ10]
    wire [7:0] cur_byte = vec_mem[ptr];

    // Read data selection
    wire [7:0] cfg_view = {5'h00, software_cal_trigger,
                           trigger_source_select, background_cal_enable};
    wire seq_open       = (ptr != '0);                       // [RQ14]
    wire [7:0] stat_view = {3'h0, state, seq_open, access_err,
                            cal_stopped};
    wire [7:0] rd_byte =
        hit_ctrl ? lp_ctrl :
        hit_den  ? data_en_reg :
        hit_data ? (port_en ? cur_byte : 8'h00) :            // [RQ9]
        hit_cfg  ? cfg_view :
        hit_stat ? stat_view : 8'h00;

    // Sequencer qualifiers
    wire lp_active = lowpower_cal_enable & background_cal_enable; // [RQ6]
    wire sel_trigger = trigger_source_select ?
        cal_trigger_input : software_cal_trigger;            // [RQ16]
    wire [lpcal_pkg::EXP_W-1:0] sleep_exp =
        SLEEP_EXPS[sleep_duration_code*lpcal_pkg::EXP_W +: lpcal_pkg::EXP_W];
    wire [lpcal_pkg::EXP_W-1:0] wake_exp =
        WAKE_EXPS[wake_settle_code*lpcal_pkg::EXP_W +: lpcal_pkg::EXP_W];
    wire [lpcal_pkg::CNT_W-1:0] sleep_lim =
        ((48'h1 << sleep_exp) + 48'h1) * CYC_UNIT;           // [RQ1]
    wire [lpcal_pkg::CNT_W-1:0] wake_lim =
        ((48'h1 << wake_exp) + 48'h1) * CYC_UNIT;            // [RQ2]
    wire sleep_over = triggered_sleep_mode ?
        ~sel_trigger :                                       // [RQ5]
        (cnt == sleep_lim - 48'h1);                          // [RQ3] [RQ4]
    wire settle_over = (cnt == wake_lim - 48'h1);            // [RQ3]

    always_comb begin
        next_state = state;
        unique case (state)
            lpcal_pkg::ST_IDLE:   if (lp_active) begin
                next_state = lpcal_pkg::ST_SLEEP;
            end
            lpcal_pkg::ST_SLEEP:  if (sleep_over) begin
                next_state = lpcal_pkg::ST_SETTLE;           // [RQ17]
            end
            lpcal_pkg::ST_SETTLE: if (settle_over) begin
                next_state = lpcal_pkg::ST_CAL;
            end
            lpcal_pkg::ST_CAL:    if (cal_cycle_done) begin
                next_state = lpcal_pkg::ST_SLEEP;            // [RQ17]
            end
        endcase
        if (!lp_active) begin
            next_state = lpcal_pkg::ST_IDLE;                 // [RQ6]
        end
    end

    // Sequencer state, phase counter and core outputs
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state      <= lpcal_pkg::ST_IDLE;
            cnt        <= '0;
            core_sleep <= 1'b0;
            cal_run    <= 1'b0;
        end else begin
            state      <= next_state;
            cnt        <= (next_state != state) ? '0 : cnt + 48'h1; // [RQ17]
            core_sleep <= (next_state == lpcal_pkg::ST_SLEEP);
            cal_run    <= (next_state == lpcal_pkg::ST_CAL);
        end
    end

    // Stopped flag tracks the engine
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cal_stopped <= 1'b0;
        end else begin
            cal_stopped <= background_cal_enable ?
                bg_cal_halted : fg_cal_done;                 // [RQ15]
        end
    end

    // APB answer: one wait state, registered data
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end else begin
            pready  <= acc_first;
            pslverr <= acc_first & ~mapped;
            if (acc_first) begin
                prdata <= {24'h000000, rd_byte};             // [RQ10]
            end
        end
    end

    // Software registers
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            lp_ctrl               <= lpcal_pkg::LP_CTRL_RST; // [RQ1] [RQ2]
            data_en_reg           <= lpcal_pkg::DATA_EN_RST;
            background_cal_enable <=
                lpcal_pkg::CFG_RST[lpcal_pkg::CFG_BG_BIT];
            trigger_source_select <=
                lpcal_pkg::CFG_RST[lpcal_pkg::CFG_SEL_BIT];
            software_cal_trigger  <=
                lpcal_pkg::CFG_RST[lpcal_pkg::CFG_SOFT_BIT];
        end else if (wr_done) begin
            if (hit_ctrl) begin
                lp_ctrl <= pwdata[7:0];
            end
            if (hit_den) begin
                data_en_reg <= pwdata[7:0];
            end
            if (hit_cfg) begin
                background_cal_enable <= pwdata[lpcal_pkg::CFG_BG_BIT];
                trigger_source_select <= pwdata[lpcal_pkg::CFG_SEL_BIT];
                software_cal_trigger  <= pwdata[lpcal_pkg::CFG_SOFT_BIT];
            end
        end
    end

    // Vector pointer and access-while-running flag
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ptr        <= '0;
            access_err <= 1'b0;
        end else begin
            if (en_newly_set) begin
                ptr <= '0;                                   // [RQ18]
            end else if (data_acc) begin
                ptr <= ptr_inc;                              // [RQ10] [RQ11]
            end
            if (data_acc && !cal_stopped) begin
                access_err <= 1'b1;                          // [RQ13]
            end else if (en_newly_set) begin
                access_err <= 1'b0;
            end
        end
    end

    // Calibration vector storage
    always_ff @(posedge clk) begin
        if (data_wr) begin
            vec_mem[ptr] <= pwdata[7:0];                     // [RQ11]
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            vec_rd_data <= '0;
        end else begin
            vec_rd_data <= (vec_rd_addr <= lpcal_pkg::PTR_LAST) ?
                vec_mem[vec_rd_addr] : 8'h00;
        end
    end

    // Checks
    a_lp_gate: assert property ( // [RQ6]
        @(posedge clk) disable iff (!rstn)
        !lp_active |=> state == lpcal_pkg::ST_IDLE)
        else $error("sequencer active without both enables");
    a_sleep_hold: assert property ( // [RQ1]
        @(posedge clk) disable iff (!rstn)
        (state == lpcal_pkg::ST_SLEEP) && lp_active && !triggered_sleep_mode
        && (cnt < sleep_lim - 48'h1) && $stable(lp_ctrl)
        |=> state == lpcal_pkg::ST_SLEEP)
        else $error("timed sleep ended early");
    a_sleep_end: assert property ( // [RQ4]
        @(posedge clk) disable iff (!rstn)
        (state == lpcal_pkg::ST_SLEEP) && lp_active && !triggered_sleep_mode
        && (cnt == sleep_lim - 48'h1)
        |=> (state == lpcal_pkg::ST_SETTLE) && (cnt == '0))
        else $error("timed sleep did not end at its count");
    a_settle_end: assert property ( // [RQ2]
        @(posedge clk) disable iff (!rstn)
        (state == lpcal_pkg::ST_SETTLE) && lp_active
        && (cnt == wake_lim - 48'h1)
        |=> (state == lpcal_pkg::ST_CAL) && cal_run)
        else $error("settling did not lead to calibration");
    a_trig_wake: assert property ( // [RQ5]
        @(posedge clk) disable iff (!rstn)
        (state == lpcal_pkg::ST_SLEEP) && lp_active && triggered_sleep_mode
        && !sel_trigger |=> state == lpcal_pkg::ST_SETTLE)
        else $error("low trigger did not wake core");
    a_trig_hold: assert property ( // [RQ4]
        @(posedge clk) disable iff (!rstn)
        (state == lpcal_pkg::ST_SLEEP) && lp_active && triggered_sleep_mode
        && sel_trigger |=> state == lpcal_pkg::ST_SLEEP)
        else $error("triggered sleep ended without trigger");
    a_cnt_restart: assert property ( // [RQ17]
        @(posedge clk) disable iff (!rstn)
        (next_state != state) |=> (cnt == '0) ##1 (cnt <= 48'h1))
        else $error("phase counter did not restart");
    a_ptr_step: assert property ( // [RQ10]
        @(posedge clk) disable iff (!rstn)
        data_acc |=> ptr == ($past(ptr_at_end) ? '0 : $past(ptr) + 10'h001))
        else $error("pointer did not advance by one");
    a_ptr_restart: assert property ( // [RQ18]
        @(posedge clk) disable iff (!rstn)
        en_newly_set |=> (ptr == '0) && port_en)
        else $error("pointer not restarted on enable");
    a_port_gated: assert property ( // [RQ9]
        @(posedge clk) disable iff (!rstn)
        acc_done && hit_data && !port_en && !en_newly_set
        |=> $stable(ptr))
        else $error("disabled port moved pointer");
    a_stop_follow: assert property ( // [RQ15]
        @(posedge clk) disable iff (!rstn)
        background_cal_enable && bg_cal_halted |=> cal_stopped)
        else $error("stopped flag missed halt");
    a_run_err: assert property ( // [RQ13]
        @(posedge clk) disable iff (!rstn)
        data_acc && !cal_stopped |=> access_err [*2])
        else $error("access while running not flagged");

    c_full_cycle: cover property (@(posedge clk) disable iff (!rstn)
        state == lpcal_pkg::ST_CAL ##1 state == lpcal_pkg::ST_SLEEP);
    c_vec_wrap: cover property (@(posedge clk) disable iff (!rstn)
        data_acc && ptr_at_end);
    c_trig_wake: cover property (@(posedge clk) disable iff (!rstn)
        state == lpcal_pkg::ST_SLEEP && triggered_sleep_mode && !sel_trigger);
    c_run_access: cover property (@(posedge clk) disable iff (!rstn)
        data_acc && !cal_stopped);
endmodule : lpcal_top

/* verif/tb_lpcal_top.sv */
// Self-checking bench for the low-power calibration sequencer and data port.
// Assumes lpcal_pkg is compiled first; drives APB and engine pins itself.
`timescale 1ns/1ps
module tb_lpcal_top;
    localparam logic [7:0]  A_LP  = lpcal_pkg::IDX_LP_CTRL;
    localparam logic [7:0]  A_EN  = lpcal_pkg::IDX_DATA_EN;
    localparam logic [7:0]  A_DAT = lpcal_pkg::IDX_DATA;
    localparam logic [7:0]  A_CFG = lpcal_pkg::IDX_CFG;
    localparam logic [7:0]  A_ST  = lpcal_pkg::IDX_STATUS;
    localparam logic [31:0] ALL   = 32'hFFFFFFFF;
    logic        clk;
    logic        rstn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        cal_trigger_input;
    logic        bg_cal_halted;
    logic        fg_cal_done;
    logic        cal_cycle_done;
    logic        core_sleep;
    logic        cal_run;
    logic [9:0]  vec_rd_addr;
    logic [7:0]  vec_rd_data;
    int          bad_count;
    int          checks;

    // Short delays: code c sleeps 2^c+1 cycles, wake code w settles 2^w+1
    lpcal_top #(
        .CYC_UNIT   (48'h1),
        .SLEEP_EXPS ({6'h07, 6'h06, 6'h05, 6'h04, 6'h03, 6'h02, 6'h01, 6'h00}),
        .WAKE_EXPS  ({6'h03, 6'h02, 6'h01, 6'h00})
    ) lpcal_top_i (
        .clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr),
        .cal_trigger_input(cal_trigger_input),
        .bg_cal_halted(bg_cal_halted), .fg_cal_done(fg_cal_done),
        .cal_cycle_done(cal_cycle_done), .core_sleep(core_sleep),
        .cal_run(cal_run), .vec_rd_addr(vec_rd_addr),
        .vec_rd_data(vec_rd_data)
    );

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : complete_run

    task automatic hang(input string nm);
        bad_count++;
        $display("CHECK FAILED %s expected response seen timeout", nm);
        complete_run();
    endtask : hang

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        checks++;
        if (g !== e) begin
            bad_count++;
            $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
        end
    endtask : chk

    // One APB transfer; waits for pready sampled high at a rising edge
    task automatic apb(input logic w, input logic [7:0] idx,
                       input logic [7:0] wd, output logic [31:0] rd,
                       output logic er);
        int n;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= {2'h0, idx, 2'h0};
        pwdata  <= {24'h0, wd};
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) hang("pready");
    endtask : apb

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, idx, d, r, e);
    endtask : wr

    task automatic rdc(input string nm, input logic [7:0] idx,
                       input logic [31:0] e, input logic ee,
                       input logic [31:0] m);
        logic [31:0] r;
        logic        er;
        apb(1'b0, idx, 8'h00, r, er);
        chk(nm, e, r & m);
        chk({nm, "_slverr"}, {31'h0, ee}, {31'h0, er});
    endtask : rdc

    task automatic step(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask : step

    // Counts cycles while the chosen output holds value v
    task automatic span(input logic on_cal, input logic v, output int n);
        n = 0;
        while ((on_cal ? cal_run : core_sleep) === v && n < 400) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (n >= 400) hang("phase");
    endtask : span

    task automatic pulse_done();
        @(posedge clk) cal_cycle_done <= 1'b1;
        @(posedge clk) cal_cycle_done <= 1'b0;
        #1;
    endtask : pulse_done

    function automatic logic [7:0] pat(input int i);
        logic [31:0] t;
        t = i * 37 + 5;
        return t[7:0];
    endfunction : pat

    task automatic t_reset();
        rdc("lp_ctrl_rst", A_LP, 32'h88, 1'b0, ALL);
        rdc("data_en_rst", A_EN, 32'h00, 1'b0, ALL);
        rdc("cfg_rst", A_CFG, 32'h04, 1'b0, ALL);
        rdc("unmapped", 8'h6F, 32'h00, 1'b1, ALL);
        wr(A_LP, 8'hFC);
        rdc("lp_ctrl_rw", A_LP, 32'hFC, 1'b0, ALL);
        wr(A_LP, 8'h88);
        $display("test reset done");
    endtask : t_reset

    task automatic t_gate();
        logic seen;
        seen = 1'b0;
        wr(A_CFG, 8'h04);
        wr(A_LP, 8'h89);
        repeat (12) begin
            step(1);
            seen = seen | core_sleep | cal_run;
        end
        chk("lp_without_bg", 32'h0, {31'h0, seen});
        wr(A_LP, 8'h88);
        $display("test gate done");
    endtask : t_gate

    task automatic t_auto();
        int         n;
        logic [2:0] c;
        wr(A_CFG, 8'h01);
        for (int i = 0; i < 8; i++) begin
            c = i[2:0];
            wr(A_LP, {c, c[1:0], 3'b001});
            if (i > 0) begin
                chk("cal_hold", 32'h1, {31'h0, cal_run});
                pulse_done();
            end
            span(1'b0, 1'b0, n);
            span(1'b0, 1'b1, n);
            chk("sleep_len", (1 << i) + 1, n);
            span(1'b1, 1'b0, n);
            chk("settle_len", (1 << (i % 4)) + 1, n);
        end
        wr(A_LP, 8'h88);
        step(2);
        chk("lp_off", 32'h0, {30'h0, core_sleep, cal_run});
        $display("test autonomous done");
    endtask : t_auto

    task automatic t_trig();
        int n;
        wr(A_CFG, 8'h03);
        wr(A_LP, 8'h8B);
        span(1'b0, 1'b0, n);
        step(40);
        chk("trig_hold", 32'h1, {31'h0, core_sleep});
        @(posedge clk) cal_trigger_input <= 1'b0;
        #1;
        span(1'b0, 1'b1, n);
        chk("pin_wake", 32'h1, n);
        span(1'b1, 1'b0, n);
        chk("trig_settle", 32'h3, n);
        @(posedge clk) cal_trigger_input <= 1'b1;
        pulse_done();
        span(1'b0, 1'b0, n);
        wr(A_CFG, 8'h05);
        @(posedge clk) cal_trigger_input <= 1'b0;
        step(30);
        chk("pin_ignored", 32'h1, {31'h0, core_sleep});
        wr(A_CFG, 8'h01);
        span(1'b0, 1'b1, n);
        chk("soft_wake", 32'h1, n);
        wr(A_LP, 8'h88);
        wr(A_CFG, 8'h04);
        @(posedge clk) cal_trigger_input <= 1'b1;
        $display("test triggered done");
    endtask : t_trig

    task automatic t_stop();
        @(posedge clk) fg_cal_done <= 1'b0;
        rdc("stop_fg_low", A_ST, 32'h0, 1'b0, 32'h1);
        @(posedge clk) fg_cal_done <= 1'b1;
        rdc("stop_fg_high", A_ST, 32'h1, 1'b0, 32'h1);
        wr(A_CFG, 8'h05);
        rdc("stop_bg_low", A_ST, 32'h0, 1'b0, 32'h1);
        @(posedge clk) bg_cal_halted <= 1'b1;
        rdc("stop_bg_high", A_ST, 32'h1, 1'b0, 32'h1);
        wr(A_CFG, 8'h04);
        $display("test stopped flag done");
    endtask : t_stop

    task automatic t_data();
        rdc("port_off", A_DAT, 32'h0, 1'b0, ALL);
        wr(A_EN, 8'h01);
        rdc("data_en_rw", A_EN, 32'h1, 1'b0, ALL);
        for (int i = 0; i < lpcal_pkg::VEC_LEN; i++)
            wr(A_DAT, pat(i));
        rdc("seq_closed", A_ST, 32'h01, 1'b0, ALL);
        @(posedge clk) vec_rd_addr <= 10'h2A0;
        step(2);
        chk("vec_tail", {24'h0, pat(672)}, {24'h0, vec_rd_data});
        @(posedge clk) vec_rd_addr <= 10'h3FF;
        step(2);
        chk("vec_oob", 32'h0, {24'h0, vec_rd_data});
        wr(A_EN, 8'h00);
        wr(A_DAT, 8'hFF);
        wr(A_EN, 8'h01);
        for (int i = 0; i < lpcal_pkg::VEC_LEN; i++)
            rdc("vec_byte", A_DAT, {24'h0, pat(i)}, 1'b0, ALL);
        @(posedge clk) fg_cal_done <= 1'b0;
        rdc("run_read", A_DAT, {24'h0, pat(0)}, 1'b0, ALL);
        rdc("run_flag", A_ST, 32'h06, 1'b0, ALL);
        @(posedge clk) fg_cal_done <= 1'b1;
        wr(A_EN, 8'h00);
        wr(A_EN, 8'h01);
        rdc("flag_clear", A_ST, 32'h01, 1'b0, ALL);
        wr(A_EN, 8'h00);
        $display("test data port done");
    endtask : t_data

    initial begin
        bad_count = 0;
        checks = 0;
        rstn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        cal_trigger_input = 1'b1;
        bg_cal_halted = 1'b0;
        fg_cal_done = 1'b1;
        cal_cycle_done = 1'b0;
        vec_rd_addr = 10'h000;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        t_reset();
        t_gate();
        t_auto();
        t_trig();
        t_stop();
        t_data();
        complete_run();
    end
endmodule : tb_lpcal_top
